// ### rtl/iocb_pkg.sv
// Shared constants and carrier types for the I/O channel byte interface.
package iocb_pkg;

  // ****************************************
  // Sizing
  // ****************************************
  localparam int SUBCH_MAX = 256;
  localparam int SUBCH_W = 8;
  localparam int SCW_WORDS = 4;
  localparam int SCW_WORD_W = 2;
  localparam int SHARED_SCW = 16;
  localparam int SHARED_IDX_W = 4;
  localparam int CU_MAX = 8;
  localparam int CU_W = 3;
  localparam int ADDR_W = 10;
  localparam logic [1:0] CFG_32 = 2'h0;
  localparam logic [1:0] CFG_64 = 2'h1;
  localparam logic [1:0] CFG_128 = 2'h2;
  localparam logic [1:0] CFG_256 = 2'h3;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [3:0] ONE_STEP = 4'h1;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 40000000;
  localparam int BYTE_RATE_HZ = 50000;
  localparam int BURST_RATE_HZ = 180000;
  localparam int BYTE_CYC = CLK_HZ / BYTE_RATE_HZ;
  localparam int BURST_CYC = CLK_HZ / BURST_RATE_HZ;
  localparam int PACE_W = 10;

  // ****************************************
  // Extended status word layout and link carrier types
  // ****************************************
  typedef struct packed {
    logic [2:0] detect_unit;
    logic [2:0] cause_unit;
    logic [3:0] good_retries;
    logic [3:0] chan_retries;
    logic [1:0] valid;
    logic [3:0] progress;
    logic [11:0] spare;
  } iocb_esw_t;

  typedef struct packed {
    logic [7:0] data;
    logic strobe;
  } iocb_byte_t;

  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } iocb_cs_t;

  typedef enum logic [1:0] {
    ERR_NONE, ERR_CHANNEL, ERR_CPU
  } iocb_err_t;

endpackage

// ### rtl/iocb_channel.sv
// Channel end of the tagged byte interface with subchannel bookkeeping.
`timescale 1ns/10ps
module iocb_channel (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESETN,
  // Mode and configuration
  input wire logic BYTE_MODE,
  input wire logic BURST_MODE,
  input wire logic [1:0] SUBCH_CFG,
  // Link from control unit
  input wire iocb_pkg::iocb_byte_t CU_IN,
  input wire logic CU_WRITE,
  input wire logic CU_DISCONNECT,
  input wire logic [2:0] CU_ADDR,
  input wire logic CU_RETRY_REQ,
  // Link to control unit
  output iocb_pkg::iocb_byte_t CH_OUT,
  output logic SEL_RESET,
  // Processor side data
  input wire logic [7:0] HOST_WDATA,
  output logic [7:0] HOST_RDATA,
  output logic HOST_RVALID,
  // Subchannel bookkeeping
  input wire logic SAVE_REQ,
  input wire logic [7:0] SAVE_SUBCH,
  input wire logic [31:0] SAVE_WORD,
  output logic SUBCH_BAD,
  output logic SHARED_BUSY,
  // Error reporting
  input wire iocb_pkg::iocb_err_t ERR_IN,
  input wire logic [2:0] ERR_CAUSE,
  output iocb_pkg::iocb_cs_t CS_WR,
  output logic IO_INT
);

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta_q, rst_n_q;
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // Subchannel limit for the configured size.
  function automatic logic [8:0] subch_limit(input logic [1:0] cfg);
    unique case (cfg)
      iocb_pkg::CFG_32: subch_limit = 9'd32;
      iocb_pkg::CFG_64: subch_limit = 9'd64;
      iocb_pkg::CFG_128: subch_limit = 9'd128;
      iocb_pkg::CFG_256: subch_limit = 9'(iocb_pkg::SUBCH_MAX);
    endcase
  endfunction

  // ****************************************
  // Strobe handshake
  // ****************************************
  typedef enum logic [1:0] {HS_IDLE, HS_ANSWER, HS_PACE} iocb_hs_t;
  iocb_hs_t hs_q, hs_d;
  iocb_pkg::iocb_byte_t out_q, out_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic [iocb_pkg::PACE_W-1:0] pace_q, pace_d;
  logic sel_rst_q, sel_rst_d;
  logic unit_ok;
  assign unit_ok = ({1'b0, CU_ADDR} < 4'(iocb_pkg::CU_MAX));

  always_comb begin
    hs_d = hs_q;
    out_d = out_q;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    pace_d = pace_q;
    sel_rst_d = CU_DISCONNECT;
    if (CU_DISCONNECT) begin
      hs_d = HS_IDLE;
      out_d = '0;
    end else begin
      unique case (hs_q)
        HS_IDLE: begin
          // Strobe answered only when inbound strobe seen and unit legal.
          if (CU_IN.strobe && unit_ok) begin
            out_d.strobe = 1'b1;
            if (CU_WRITE) begin
              out_d.data = HOST_WDATA;
            end else begin
              rdata_d = CU_IN.data;
              rvalid_d = 1'b1;
            end
            hs_d = HS_ANSWER;
          end
        end
        HS_ANSWER: begin
          // Hold the answer until the inbound strobe drops.
          if (!CU_IN.strobe) begin
            out_d.strobe = 1'b0;
            // Byte mode waits out a fixed gap so the link never beats its rate.
            // Strobes that arrive meanwhile wait; the control unit holds them.
            pace_d = BURST_MODE ?
              iocb_pkg::PACE_W'(iocb_pkg::BURST_CYC) :
              iocb_pkg::PACE_W'(iocb_pkg::BYTE_CYC);
            hs_d = BYTE_MODE ? HS_PACE : HS_IDLE;
          end
        end
        HS_PACE: begin
          pace_d = pace_q - 1'b1;
          if (pace_q <= iocb_pkg::PACE_W'(1)) begin
            hs_d = HS_IDLE;
          end
        end
        default: hs_d = HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      hs_q <= HS_IDLE;
      out_q <= '0;
      rdata_q <= iocb_pkg::ZERO_BYTE;
      rvalid_q <= 1'b0;
      pace_q <= '0;
      sel_rst_q <= 1'b0;
    end else begin
      hs_q <= hs_d;
      out_q <= out_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      pace_q <= pace_d;
      sel_rst_q <= sel_rst_d;
    end
  end

  // ****************************************
  // Subchannel control word saving
  // ****************************************
  // Shared words are owned by one device at a time; only a busy bit is recorded
  // per word, so a second device cannot overwrite the active state.
  logic [iocb_pkg::SHARED_SCW-1:0] sh_busy_q, sh_busy_d;
  logic [1:0] wcnt_q, wcnt_d;
  logic saving_q, saving_d;
  logic [7:0] sub_q, sub_d;
  logic bad_q, bad_d;
  logic shbusy_o_q, shbusy_o_d;
  logic is_shared;
  logic [3:0] sh_idx;
  assign is_shared = (SAVE_SUBCH[7:4] == 4'h0);
  assign sh_idx = SAVE_SUBCH[3:0];

  always_comb begin
    sh_busy_d = sh_busy_q;
    wcnt_d = wcnt_q;
    saving_d = saving_q;
    sub_d = sub_q;
    bad_d = 1'b0;
    shbusy_o_d = 1'b0;
    if (CU_DISCONNECT) begin
      sh_busy_d = '0;
      saving_d = 1'b0;
    end else if (saving_q) begin
      wcnt_d = wcnt_q + 1'b1;
      if (wcnt_q == 2'(iocb_pkg::SCW_WORDS - 1)) begin
        saving_d = 1'b0;
      end
    end else if (SAVE_REQ) begin
      if ({1'b0, SAVE_SUBCH} >= subch_limit(SUBCH_CFG)) begin
        bad_d = 1'b1;
      end else if (is_shared && sh_busy_q[sh_idx]) begin
        // The owner cannot be told apart from a newcomer here, so any save
        // to an owned shared word is refused until a selective reset.
        shbusy_o_d = 1'b1;
      end else begin
        // Non-shared words map one-to-one onto a device address.
        sub_d = SAVE_SUBCH;
        saving_d = 1'b1;
        wcnt_d = '0;
        if (is_shared) begin
          sh_busy_d[sh_idx] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sh_busy_q <= '0;
      wcnt_q <= '0;
      saving_q <= 1'b0;
      sub_q <= '0;
      bad_q <= 1'b0;
      shbusy_o_q <= 1'b0;
    end else begin
      sh_busy_q <= sh_busy_d;
      wcnt_q <= wcnt_d;
      saving_q <= saving_d;
      sub_q <= sub_d;
      bad_q <= bad_d;
      shbusy_o_q <= shbusy_o_d;
    end
  end

  // ****************************************
  // Status storing and command retry
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE, ST_CSW, ST_ESW} iocb_st_t;
  iocb_st_t st_q, st_d;
  iocb_pkg::iocb_esw_t esw_q, esw_d;
  iocb_pkg::iocb_cs_t cs_q, cs_d;
  logic int_q, int_d;

  always_comb begin
    st_d = st_q;
    esw_d = esw_q;
    cs_d = '0;
    int_d = 1'b0;
    // Command retry is counted but never interrupts.
    if (CU_RETRY_REQ && esw_q.good_retries != 4'hf) begin
      esw_d.good_retries = esw_q.good_retries + iocb_pkg::ONE_STEP;
    end
    unique case (st_q)
      ST_IDLE: begin
        if (ERR_IN != iocb_pkg::ERR_NONE) begin
          esw_d.detect_unit = (ERR_IN == iocb_pkg::ERR_CPU) ?
            3'h0 : 3'h1;
          esw_d.cause_unit = ERR_CAUSE;
          esw_d.chan_retries = esw_q.chan_retries + iocb_pkg::ONE_STEP;
          esw_d.valid = 2'h3;
          esw_d.progress = {2'h0, hs_q};
          st_d = ST_CSW;
        end
      end
      ST_CSW: begin
        cs_d.we = 1'b1;
        cs_d.addr = '0;
        cs_d.wdata = {sub_q, rdata_q, 8'h00, CU_IN.data};
        st_d = ST_ESW;
      end
      ST_ESW: begin
        cs_d.we = 1'b1;
        cs_d.addr = iocb_pkg::ADDR_W'(1);
        cs_d.wdata = esw_q;
        int_d = 1'b1;
        st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
    if (saving_q) begin
      cs_d.we = 1'b1;
      cs_d.addr = {sub_q, wcnt_q};
      cs_d.wdata = SAVE_WORD;
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q <= ST_IDLE;
      esw_q <= '0;
      cs_q <= '0;
      int_q <= 1'b0;
    end else begin
      st_q <= st_d;
      esw_q <= esw_d;
      cs_q <= cs_d;
      int_q <= int_d;
    end
  end

  assign CH_OUT = out_q;
  assign SEL_RESET = sel_rst_q;
  assign HOST_RDATA = rdata_q;
  assign HOST_RVALID = rvalid_q;
  assign SUBCH_BAD = bad_q;
  assign SHARED_BUSY = shbusy_o_q;
  assign CS_WR = cs_q;
  assign IO_INT = int_q;

endmodule

// ### tb/iocb_cu_model.sv
// Behavioural control unit on the far side of the byte link.
`timescale 1ns/10ps
module iocb_cu_model (
  // Clock
  input wire logic clk,
  // Command from the bench
  input wire logic go,
  input wire logic [7:0] byte_in,
  input wire logic [3:0] lag,
  // Link
  input wire iocb_pkg::iocb_byte_t ch_out,
  output iocb_pkg::iocb_byte_t cu_in,
  // Result
  output logic [7:0] got,
  output int xfers
);
  initial begin
    cu_in = 9'h1fe;
    got = 8'h00;
    xfers = 0;
    forever begin
      @(posedge clk);
      if (go) begin
        #2 cu_in = {byte_in, 1'b1};
        @(posedge clk);
        while (ch_out.strobe !== 1'b1) @(posedge clk);
        got = ch_out.data;
        repeat (lag) @(posedge clk);
        // A released bus shows the inverse, so stale data never matches.
        #2 cu_in = {~byte_in, 1'b0};
        @(posedge clk);
        while (ch_out.strobe !== 1'b0) @(posedge clk);
        xfers++;
      end
    end
  end
endmodule

// ### tb/iocb_channel_chk.sv
// Port-level assertions for the channel block.
`timescale 1ns/10ps
module iocb_channel_chk (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESETN,
  // Watched ports
  input wire iocb_pkg::iocb_byte_t CU_IN,
  input wire logic CU_DISCONNECT,
  input wire logic SAVE_REQ,
  input wire logic [7:0] SAVE_SUBCH,
  input wire logic [1:0] SUBCH_CFG,
  input wire iocb_pkg::iocb_err_t ERR_IN,
  input wire iocb_pkg::iocb_byte_t CH_OUT,
  input wire logic SEL_RESET,
  input wire logic [7:0] HOST_RDATA,
  input wire logic HOST_RVALID,
  input wire logic SUBCH_BAD,
  input wire iocb_pkg::iocb_cs_t CS_WR,
  input wire logic IO_INT
);
  logic [2:0] up_q;
  // Internal reset lags the pin, so a_cause and a_reset wait until it has surely gone.
  always_ff @(posedge CORE_CLK or negedge RESETN)
    if (!RESETN) up_q <= 3'h0;
    else if (up_q != 3'h7) up_q <= up_q + 3'h1;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  sequence s_words;
    CS_WR.we && CS_WR.addr[1:0] == 2'h0 ##1 CS_WR.addr[1:0] == 2'h1
    ##1 CS_WR.addr[1:0] == 2'h2 ##1 CS_WR.we && CS_WR.addr[1:0] == 2'h3;
  endsequence
  sequence s_status;
    CS_WR.we && CS_WR.addr == 10'h000 ##1 IO_INT && CS_WR.addr == 10'h001;
  endsequence
  property p_cause;
    $rose(CH_OUT.strobe) && up_q == 3'h7 |-> $past(CU_IN.strobe);
  endproperty
  a_cause: assert property (p_cause) else $error("unasked strobe");
  property p_hold;
    CH_OUT.strobe && CU_IN.strobe |=> CH_OUT.strobe;
  endproperty
  a_hold: assert property (p_hold) else $error("strobe dropped");
  property p_drop;
    CH_OUT.strobe && !CU_IN.strobe |-> ##[1:2] !CH_OUT.strobe;
  endproperty
  a_drop: assert property (p_drop) else $error("strobe stuck");
  property p_rdata;
    HOST_RVALID |-> HOST_RDATA == $past(CU_IN.data) && $past(CU_IN.strobe);
  endproperty
  a_rdata: assert property (p_rdata) else $error("bad read byte");
  property p_reset;
    up_q == 3'h7 |=> SEL_RESET == $past(CU_DISCONNECT);
  endproperty
  a_reset: assert property (p_reset) else $error("no reset");
  property p_save;
    $rose(SAVE_REQ) && SAVE_SUBCH[7:4] == 4'h1 && !CS_WR.we |->
      ##2 CS_WR.addr[9:2] == $past(SAVE_SUBCH, 2) ##0 s_words;
  endproperty
  a_save: assert property (p_save) else $error("bad save");
  property p_bad;
    $rose(SAVE_REQ) && SUBCH_CFG == iocb_pkg::CFG_32 && SAVE_SUBCH[7:5] != 3'h0
      |-> ##[1:2] SUBCH_BAD;
  endproperty
  a_bad: assert property (p_bad) else $error("limit missed");
  property p_err;
    $rose(ERR_IN != iocb_pkg::ERR_NONE) && !CS_WR.we |-> ##2 s_status;
  endproperty
  a_err: assert property (p_err) else $error("no status");
endmodule

// ### tb/testbench.sv
// Self-checking bench for the channel byte interface.
`timescale 1ns/10ps
module testbench;
  logic core_clk, resetn, cu_write, cu_disc, save_req, go, rvalid, bad;
  logic sel_rst, io_int, byte_mode, burst_mode, cu_retry, sb, ch_prev;
  logic [2:0] err_cause;
  iocb_pkg::iocb_esw_t esw;
  logic [1:0] subch_cfg;
  logic [3:0] lag;
  logic [7:0] wdata, save_subch, cu_byte, got, rdata;
  logic [9:0] wq[$];
  iocb_pkg::iocb_byte_t cu_in, ch_out;
  iocb_pkg::iocb_cs_t cs_wr;
  iocb_pkg::iocb_err_t err_in;
  int error_cnt, checks_done, cyc, xfers, rv_cnt, bad_cnt, int_cnt;
  int sb_cnt, fall_cyc, rise_gap;
  iocb_channel i_iocb_channel (.CORE_CLK(core_clk), .RESETN(resetn),
    .BYTE_MODE(byte_mode), .BURST_MODE(burst_mode), .SUBCH_CFG(subch_cfg),
    .CU_IN(cu_in), .CU_WRITE(cu_write), .CU_DISCONNECT(cu_disc),
    .CU_ADDR(3'h2), .CU_RETRY_REQ(cu_retry), .CH_OUT(ch_out),
    .SEL_RESET(sel_rst), .HOST_WDATA(wdata), .HOST_RDATA(rdata),
    .HOST_RVALID(rvalid), .SAVE_REQ(save_req), .SAVE_SUBCH(save_subch),
    .SAVE_WORD({save_subch, 24'h5a0f3c}), .SUBCH_BAD(bad),
    .SHARED_BUSY(sb), .ERR_IN(err_in), .ERR_CAUSE(err_cause), .CS_WR(cs_wr),
    .IO_INT(io_int));
  iocb_cu_model i_iocb_cu_model (.clk(core_clk), .go(go), .byte_in(cu_byte),
    .lag(lag), .ch_out(ch_out), .cu_in(cu_in), .got(got), .xfers(xfers));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task automatic xfer(input logic wr, input logic [7:0] b, input int l);
    int n;
    n = xfers;
    cu_write = wr;
    wdata = b;
    cu_byte = wr ? ~b : b;
    lag = l[3:0];
    go = 1'b1;
    tick(1);
    go = 1'b0;
    while (xfers == n) tick(1);
  endtask
  task automatic pulse_save(input logic [7:0] s);
    save_subch = s;
    save_req = 1'b1;
    tick(1);
    save_req = 1'b0;
    tick(8);
  endtask
  task automatic chk_words(input logic [7:0] s);
    chk(wq.size(), 4);
    foreach (wq[k]) chk(wq[k], {s, k[1:0]});
    wq.delete();
  endtask
  task automatic chk_gap(input int lo);
    chk(rise_gap >= lo && rise_gap <= lo + 4, 1);
  endtask
  task automatic t_link;
    xfer(1'b0, 8'h5a, 3);
    chk(rdata, 8'h5a);
    chk(rv_cnt, 1);
    xfer(1'b1, 8'hc3, 0);
    chk(got, 8'hc3);
    chk(rv_cnt, 1);
    xfer(1'b0, 8'h81, 0);
    chk(rdata, 8'h81);
  endtask
  task automatic t_save;
    logic [8:0] lim;
    subch_cfg = iocb_pkg::CFG_32;
    pulse_save(8'h13);
    chk_words(8'h13);
    pulse_save(8'h20);
    chk(bad_cnt, 1);
    chk(wq.size(), 0);
    pulse_save(8'h03);
    chk_words(8'h03);
    pulse_save(8'h03);
    chk(sb_cnt, 1);
    chk(wq.size(), 0);
    for (int c = 1; c < 4; c++) begin
      subch_cfg = 2'(c);
      lim = 9'h020 << c;
      pulse_save(8'(lim - 9'h001));
      chk_words(8'(lim - 9'h001));
      if (c < 3) begin
        pulse_save(lim[7:0]);
        chk(wq.size(), 0);
      end
    end
    chk(bad_cnt, 3);
  endtask
  task automatic t_status;
    cu_retry = 1'b1;
    tick(3);
    cu_retry = 1'b0;
    tick(2);
    chk(int_cnt, 0);
    for (int e = 1; e < 3; e++) begin
      err_in = iocb_pkg::iocb_err_t'(e);
      err_cause = 3'(e + 4);
      tick(1);
      err_in = iocb_pkg::ERR_NONE;
      tick(6);
      chk(wq.size(), 2);
      chk(wq[0], 10'h000);
      chk(wq[1], 10'h001);
      wq.delete();
      chk({esw.detect_unit, esw.cause_unit},
        {(e == 2) ? 3'h0 : 3'h1, 3'(e + 4)});
      chk({esw.good_retries, esw.chan_retries}, {4'h3, 4'(e)});
    end
    chk(int_cnt, 2);
  endtask
  task automatic t_pace;
    byte_mode = 1'b1;
    burst_mode = 1'b1;
    xfer(1'b0, 8'h33, 0);
    xfer(1'b0, 8'h44, 0);
    chk_gap(iocb_pkg::BURST_CYC);
    chk(rdata, 8'h44);
    burst_mode = 1'b0;
    xfer(1'b0, 8'h55, 0);
    xfer(1'b1, 8'h66, 0);
    chk_gap(iocb_pkg::BYTE_CYC);
    chk(got, 8'h66);
    byte_mode = 1'b0;
  endtask
  task automatic t_disc;
    cu_disc = 1'b1;
    tick(2);
    chk(sel_rst, 1'b1);
    cu_disc = 1'b0;
    tick(2);
    chk(sel_rst, 1'b0);
    xfer(1'b0, 8'h96, 0);
    chk(rdata, 8'h96);
    pulse_save(8'h03);
    chk_words(8'h03);
    chk(sb_cnt, 1);
  endtask
  task final_report;
    $display("checks=%0d errors=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cs_wr.we === 1'b1) wq.push_back(cs_wr.addr);
    if (cs_wr.we === 1'b1 && cs_wr.addr === 10'h001) esw = cs_wr.wdata;
    rv_cnt += (rvalid === 1'b1);
    bad_cnt += (bad === 1'b1);
    sb_cnt += (sb === 1'b1);
    int_cnt += (io_int === 1'b1);
    if (ch_out.strobe === 1'b0 && ch_prev === 1'b1) fall_cyc = cyc;
    if (ch_out.strobe === 1'b1 && ch_prev === 1'b0)
      rise_gap = cyc - fall_cyc;
    ch_prev = ch_out.strobe;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    {resetn, cu_write, cu_disc, save_req, go, lag} = '0;
    {byte_mode, burst_mode, cu_retry, err_cause} = '0;
    {subch_cfg, wdata, save_subch, cu_byte} = '0;
    err_in = iocb_pkg::ERR_NONE;
    tick(20);
    resetn = 1'b1;
    tick(4);
    t_link();
    t_save();
    t_status();
    t_pace();
    t_disc();
    final_report();
  end
endmodule
bind iocb_channel iocb_channel_chk i_iocb_channel_chk (.CORE_CLK, .RESETN,
  .CU_IN, .CU_DISCONNECT, .SAVE_REQ, .SAVE_SUBCH, .SUBCH_CFG, .ERR_IN,
  .CH_OUT, .SEL_RESET, .HOST_RDATA, .HOST_RVALID, .SUBCH_BAD, .CS_WR, .IO_INT);
